// File: pkg/sram_ctl_cfg.svh
// constants for the burst sram control-input model and its controller
// assumes inclusion by bare name from pkg and hw files
`ifndef SRAM_CTL_CFG_SVH
`define SRAM_CTL_CFG_SVH
`define LANES         8
`define LANE_BITS     8
`define ADDR_BITS     10
`define BURST_BITS    2
`define SEL_NONE      8'hFF
`endif

// File: pkg/sram_ctl_pkg.sv
// types shared by both ends of the burst sram link
// assumes sram_ctl_cfg.svh on the include path
`include "sram_ctl_cfg.svh"
package sram_ctl_pkg;
  typedef logic [`LANE_BITS-1:0] lane_t;
  typedef lane_t [`LANES-1:0]    word_t;
  typedef logic [`LANES-1:0]     par_t;
  // controller command kinds
  typedef enum logic [1:0] {
    CMD_IDLE  = 2'h0,
    CMD_READ  = 2'h1,
    CMD_WRITE = 2'h3,
    CMD_BURST = 2'h2
  } cmd_t;
endpackage

// File: pkg/sram_link_if.sv
// pin-level link between the burst sram model and its controller
// assumes one shared sys_clk; resolves the data bus from the two enables
`timescale 1ns/1ps
`include "sram_ctl_cfg.svh"
interface sram_link_if;
  logic [`ADDR_BITS-1:0]   addr;
  logic                    burst_addr_bit_zero;
  logic                    burst_addr_bit_one;
  logic [`LANES-1:0]       byte_lane_write_sel_n;
  logic                    write_n;
  logic                    advance_or_load;
  logic                    clock_qualifier_n;
  logic                    chip_select_first_n;
  logic                    chip_select_second;
  logic                    chip_select_third_n;
  logic                    output_enable_n;
  sram_ctl_pkg::word_t     dq_ctl;
  sram_ctl_pkg::par_t      par_ctl;
  logic                    dq_ctl_oe;
  sram_ctl_pkg::word_t     dq_mem;
  sram_ctl_pkg::par_t      par_mem;
  logic                    dq_mem_oe;
  sram_ctl_pkg::word_t     dq;
  sram_ctl_pkg::par_t      parity_lane;
  // neither driving reads as zero; contention is a bench matter
  assign dq          = dq_ctl_oe ? dq_ctl : (dq_mem_oe ? dq_mem : '0);
  assign parity_lane = dq_ctl_oe ? par_ctl : (dq_mem_oe ? par_mem : '0);
  modport memory (
    input  addr, burst_addr_bit_zero, burst_addr_bit_one, byte_lane_write_sel_n, write_n,
           advance_or_load, clock_qualifier_n, chip_select_first_n, chip_select_second,
           chip_select_third_n, output_enable_n, dq, parity_lane,
    output dq_mem, par_mem, dq_mem_oe
  );
  modport controller (
    output addr, burst_addr_bit_zero, burst_addr_bit_one, byte_lane_write_sel_n, write_n,
           advance_or_load, clock_qualifier_n, chip_select_first_n, chip_select_second,
           chip_select_third_n, output_enable_n, dq_ctl, par_ctl, dq_ctl_oe,
    input  dq, parity_lane
  );
endinterface // sram_link_if

// File: hw/sram_mem_end.sv
// memory end: control-input capture, burst counter, byte-lane writes, output masking
// assumes controller shares sys_clk; late-write: data follows its command by one qualified edge
//
// Contract
// - address captured on rising edge
// - lane selects low-active, need write enable
// - each select owns one byte and parity
// - write enable sampled only when qualified
// - controller drives write low to start
// - advance high increments burst counter
// - after deselect controller must load first
// - qualifier high freezes all state
// - select needs cs1 low, cs2 high, cs3 low
// - outputs off on write, wake, deselect
`timescale 1ns/1ps
`include "sram_ctl_cfg.svh"
module sram_mem_end #(
  parameter int ADDR_BITS = `ADDR_BITS
) (
  // clock and reset
  input  wire logic  sys_clk,
  input  wire logic  reset,
  // link
  sram_link_if.memory link,
  // status
  output logic       selected,
  output logic       write_seen
);
  localparam int WORDS = 1 << (ADDR_BITS + `BURST_BITS);
  initial begin
    if (ADDR_BITS < 1 || ADDR_BITS > 20) $error("sram_mem_end: ADDR_BITS out of range");
  end

  typedef struct packed {
    logic [ADDR_BITS-1:0]   hi;
    logic [`BURST_BITS-1:0] lo;
    logic                   active;
    logic                   was_write;
    logic [`LANES-1:0]      sel_n;
    logic                   wr_pend;
    logic                   rd_pend;
    logic                   wake;
    logic                   wr_seen;
  } mstate_t;

  mstate_t r, nxt;
  sram_ctl_pkg::word_t mem     [WORDS];
  sram_ctl_pkg::par_t  mem_par [WORDS];
  sram_ctl_pkg::word_t rd_r;
  sram_ctl_pkg::par_t  rdp_r;
  logic                rd_oe_r;
  sram_ctl_pkg::word_t rd_word;
  sram_ctl_pkg::par_t  rd_wpar;
  logic [ADDR_BITS+`BURST_BITS-1:0] rd_addr;

  logic                            qual;
  logic                            cs_ok;
  logic [ADDR_BITS+`BURST_BITS-1:0] cur;
  logic                            do_write;

  assign qual  = ~link.clock_qualifier_n;
  assign cs_ok = ~link.chip_select_first_n & link.chip_select_second
                 & ~link.chip_select_third_n;
  assign cur      = {r.hi, r.lo};
  assign do_write = qual & r.wr_pend;

  always_comb begin
    nxt = r;
    if (qual) begin
      nxt.wr_pend = 1'b0;
      nxt.rd_pend = 1'b0;
      nxt.wake    = 1'b0;
      if (link.advance_or_load) begin
        if (r.active) begin
          nxt.lo = r.lo + 2'h1;
          nxt.wr_pend = r.was_write;
          nxt.rd_pend = ~r.was_write;
          nxt.sel_n   = link.byte_lane_write_sel_n;
        end
      end else if (cs_ok) begin
        nxt.hi        = link.addr;
        nxt.lo        = {link.burst_addr_bit_one, link.burst_addr_bit_zero};
        nxt.wake      = ~r.active;
        nxt.active    = 1'b1;
        nxt.was_write = ~link.write_n;
        nxt.wr_pend   = ~link.write_n;
        nxt.rd_pend   = link.write_n;
        nxt.sel_n     = link.byte_lane_write_sel_n;
        nxt.wr_seen   = r.wr_seen | ~link.write_n;
      end else begin
        // a deselect clears the burst; a later advance does nothing
        nxt.active = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r <= '0;
      r.sel_n <= `SEL_NONE;
    end else begin
      r <= nxt;
    end
  end

  // memory array: held under a suspended clock, lanes gated by their selects
  always_ff @(posedge sys_clk) begin
    if (!reset && do_write) begin
      for (int i = 0; i < `LANES; i++) begin
        if (!r.sel_n[i]) begin
          mem[cur][i]     <= link.dq[i];
          mem_par[cur][i] <= link.parity_lane[i];
        end
      end
    end
  end

  // read word for the access taken at this edge; lanes being written at the
  // same edge are forwarded so a read right after a write sees the new bytes
  assign rd_addr = {nxt.hi, nxt.lo};
  always_comb begin
    rd_word = mem[rd_addr];
    rd_wpar = mem_par[rd_addr];
    for (int i = 0; i < `LANES; i++) begin
      if (do_write && cur == rd_addr && !r.sel_n[i]) begin
        rd_word[i] = link.dq[i];
        rd_wpar[i] = link.parity_lane[i];
      end
    end
  end

  // read data phase is the cycle after the access edge, the same slot a write
  // uses for its data, so turning the bus around never needs a dead cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_r    <= '0;
      rdp_r   <= '0;
      rd_oe_r <= 1'b0;
    end else if (qual) begin
      rd_oe_r <= nxt.rd_pend & ~nxt.wake;
      if (nxt.rd_pend) begin
        rd_r  <= rd_word;
        rdp_r <= rd_wpar;
      end
    end
  end

  assign link.dq_mem    = rd_r;
  assign link.par_mem   = rdp_r;
  // off during write data, the wake cycle and deselect
  assign link.dq_mem_oe = rd_oe_r & ~link.output_enable_n;
  assign selected       = r.active;
  assign write_seen     = r.wr_seen;
endmodule // sram_mem_end

// File: hw/sram_ctl_end.sv
// controller end: turns user commands into pin cycles on the burst sram link
// assumes memory shares sys_clk; write data goes out one cycle after its command
`timescale 1ns/1ps
`include "sram_ctl_cfg.svh"
module sram_ctl_end #(
  parameter int ADDR_BITS = `ADDR_BITS
) (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // user command
  input  wire logic                   cmd_valid,
  input  sram_ctl_pkg::cmd_t          cmd,
  input  wire logic [ADDR_BITS+1:0]   cmd_addr,
  input  wire logic [`LANES-1:0]      cmd_sel_n,
  input  sram_ctl_pkg::word_t         cmd_data,
  input  sram_ctl_pkg::par_t          cmd_par,
  input  wire logic                   hold,
  // user read data
  output sram_ctl_pkg::word_t         rd_data,
  output sram_ctl_pkg::par_t          rd_par,
  // link
  sram_link_if.controller             link
);
  initial begin
    if (ADDR_BITS < 1 || ADDR_BITS > 20) $error("sram_ctl_end: ADDR_BITS out of range");
  end

  typedef struct packed {
    logic [ADDR_BITS-1:0] hi;
    logic [1:0]           lo;
    logic [`LANES-1:0]    sel_n;
    logic                 write_n;
    logic                 adv;
    logic                 cs;
    logic                 qual_n;
    logic                 active;
    logic                 wr_data;
    sram_ctl_pkg::word_t  d;
    sram_ctl_pkg::par_t   p;
    sram_ctl_pkg::word_t  pd;
    sram_ctl_pkg::par_t   pp;
  } cstate_t;

  cstate_t r, nxt;

  always_comb begin
    nxt = r;
    nxt.qual_n = hold;
    // the data phase moves only on edges the memory counts, so it lines up with
    // the memory's own view even when a stall falls between command and data
    if (!r.qual_n) begin
      nxt.wr_data = (r.cs | r.adv) & ~r.write_n;
      nxt.d       = r.pd;
      nxt.p       = r.pp;
    end
    if (!hold) begin
      nxt.pd = cmd_data;
      nxt.pp = cmd_par;
      nxt.adv = 1'b0;
      nxt.cs  = 1'b0;
      nxt.write_n = 1'b1;
      nxt.sel_n = `SEL_NONE;
      if (cmd_valid) begin
        unique case (cmd)
          sram_ctl_pkg::CMD_READ, sram_ctl_pkg::CMD_WRITE: begin
            nxt.cs      = 1'b1;
            nxt.hi      = cmd_addr[ADDR_BITS+1:2];
            nxt.lo      = cmd_addr[1:0];
            nxt.write_n = (cmd != sram_ctl_pkg::CMD_WRITE);
            nxt.sel_n   = cmd_sel_n;
            nxt.active  = 1'b1;
          end
          sram_ctl_pkg::CMD_BURST: begin
            // never advance as the first access after deselect
            nxt.adv     = r.active;
            nxt.write_n = r.write_n;
            nxt.sel_n   = cmd_sel_n;
          end
          sram_ctl_pkg::CMD_IDLE: nxt.active = 1'b0;
        endcase
      end else begin
        nxt.active = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r <= '0;
      r.sel_n   <= `SEL_NONE;
      r.write_n <= 1'b1;
      r.qual_n  <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_data <= '0;
      rd_par  <= '0;
    end else begin
      rd_data <= link.dq;
      rd_par  <= link.parity_lane;
    end
  end

  // every control pin but the tied-low output_enable_n comes straight from a flip-flop so it is stable at the edge
  assign link.addr                  = r.hi;
  assign link.burst_addr_bit_zero   = r.lo[0];
  assign link.burst_addr_bit_one    = r.lo[1];
  assign link.byte_lane_write_sel_n = r.sel_n;
  assign link.write_n               = r.write_n;
  assign link.advance_or_load       = r.adv;
  assign link.clock_qualifier_n     = r.qual_n;
  assign link.chip_select_first_n   = ~r.cs;
  assign link.chip_select_second    = r.cs;
  assign link.chip_select_third_n   = ~r.cs;
  assign link.output_enable_n       = 1'b0;
  assign link.dq_ctl                = r.d;
  assign link.par_ctl               = r.p;
  assign link.dq_ctl_oe             = r.wr_data;
endmodule // sram_ctl_end

// File: bench/sram_link_asserts.sv
// link checker: watches the pins between the controller and the memory
// assumes one sys_clk and a synchronous active-high reset
`timescale 1ns/1ps
module sram_link_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // link
  input wire logic write_n,
  input wire logic advance_or_load,
  input wire logic clock_qualifier_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic dq_ctl_oe,
  input wire logic dq_mem_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic sel;
  logic desel_r;
  assign sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  // only qualified non-advance edges (loads and deselects) change selection, advances keep it
  always_ff @(posedge sys_clk) begin
    if (reset) desel_r <= 1'b1;
    else if (!clock_qualifier_n && !advance_or_load) desel_r <= !sel;
  end
  sequence load_s; !clock_qualifier_n && sel && !advance_or_load; endsequence
  sequence rd_load_s; load_s ##0 write_n; endsequence
  sequence wr_load_s; load_s ##0 !write_n; endsequence

  no_contention_a: assert property (!(dq_ctl_oe && dq_mem_oe))
    else $error("both ends drive the data bus");
  reset_quiet_a: assert property ($fell(reset) |-> !dq_ctl_oe && !dq_mem_oe && write_n && clock_qualifier_n)
    else $error("link not quiet after reset");
  write_data_a: assert property (wr_load_s |=> dq_ctl_oe)
    else $error("write data not driven after write load");
  wr_oe_cause_a: assert property ($rose(dq_ctl_oe) |-> $past(!write_n))
    else $error("controller drove data without a write");
  read_drive_a: assert property (!desel_r ##0 rd_load_s |=> dq_mem_oe)
    else $error("memory did not drive read data");
  wake_mask_a: assert property (desel_r ##0 rd_load_s |=> !dq_mem_oe)
    else $error("memory drove on first cycle after deselect");
  desel_off_a: assert property (!clock_qualifier_n && !sel && !advance_or_load |=> !dq_mem_oe)
    else $error("memory drove while deselected");
  stall_hold_a: assert property (clock_qualifier_n |=> $stable(dq_mem_oe))
    else $error("memory output changed on a masked edge");
  load_first_a: assert property (!clock_qualifier_n && desel_r |-> !advance_or_load)
    else $error("advance issued after deselect");
endmodule // sram_link_asserts

// File: bench/testbench.sv
// top bench: controller and memory joined by the link, scoreboard on read data
// assumes both ends share sys_clk; reads land in issue order
`timescale 1ns/1ps
`include "sram_ctl_cfg.svh"
module testbench;
  typedef logic [`ADDR_BITS+1:0] addr_t;
  typedef struct packed {sram_ctl_pkg::word_t d; sram_ctl_pkg::par_t p;} ent_t;
  localparam sram_ctl_pkg::cmd_t WR = sram_ctl_pkg::CMD_WRITE;
  localparam sram_ctl_pkg::cmd_t RD = sram_ctl_pkg::CMD_READ;
  localparam sram_ctl_pkg::cmd_t BU = sram_ctl_pkg::CMD_BURST;
  localparam sram_ctl_pkg::cmd_t ID = sram_ctl_pkg::CMD_IDLE;
  logic                sys_clk, reset, cmd_valid, hold, selected, write_seen;
  logic                pend, cqn_prev, desel, wr;
  sram_ctl_pkg::cmd_t  cmd;
  addr_t               cmd_addr, cur, b;
  logic [`LANES-1:0]   cmd_sel_n;
  sram_ctl_pkg::word_t cmd_data, rd_data;
  sram_ctl_pkg::par_t  cmd_par, rd_par;
  ent_t                mdl [1 << (`ADDR_BITS+2)];
  ent_t                exp_q [$];
  int                  n_errors, num_checks;
  sram_link_if link ();
  sram_mem_end sram_mem_end_i (.sys_clk, .reset, .link, .selected, .write_seen);
  sram_ctl_end sram_ctl_end_i (.sys_clk, .reset, .cmd_valid, .cmd, .cmd_addr, .cmd_sel_n,
    .cmd_data, .cmd_par, .hold, .rd_data, .rd_par, .link);
  sram_link_asserts sram_link_asserts_i (.sys_clk, .reset, .write_n(link.write_n),
    .advance_or_load(link.advance_or_load), .clock_qualifier_n(link.clock_qualifier_n),
    .chip_select_first_n(link.chip_select_first_n), .chip_select_second(link.chip_select_second),
    .chip_select_third_n(link.chip_select_third_n), .dq_ctl_oe(link.dq_ctl_oe),
    .dq_mem_oe(link.dq_mem_oe));

  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(string nm, logic [71:0] seen, logic [71:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // random stalls on every command, so the masked edges are crossed everywhere
  task automatic issue(sram_ctl_pkg::cmd_t c, addr_t a, logic [`LANES-1:0] s);
    ent_t e;
    e = {$urandom, $urandom, 8'($urandom)};
    if (c == BU) a = {cur[`ADDR_BITS+1:2], cur[1:0] + 2'h1};
    cur = a;
    cmd_valid = 1;
    cmd = c;
    cmd_addr = a;
    cmd_sel_n = s;
    {cmd_data, cmd_par} = e;
    for (int n = 0; n < 9; n++) begin
      hold = (n < 8) && ($urandom_range(3) == 0);
      @(posedge sys_clk);
      #1;
      if (!hold) break;
    end
    if (c == WR) wr = 1;
    else if (c == RD) wr = 0;
    if (c != ID && wr) begin
      for (int i = 0; i < `LANES; i++) if (!s[i]) begin
        mdl[a].d[i] = e.d[i];
        mdl[a].p[i] = e.p[i];
      end
    end else if (c != ID && !desel) exp_q.push_back(mdl[a]);
    desel = (c == ID);
  endtask

  always @(posedge sys_clk) begin
    if (pend) begin
      if (exp_q.size() == 0) chk("rd_extra", 72'h1, 72'h0);
      else chk("rd_data", {rd_data, rd_par}, exp_q.pop_front());
    end
    pend <= !reset && link.dq_mem_oe && !cqn_prev;
    cqn_prev <= link.clock_qualifier_n;
  end

  initial begin
    {cmd_valid, hold, pend, cqn_prev, wr, n_errors, num_checks} = '0;
    desel = 1;
    cmd = ID;
    {cmd_addr, cur, cmd_data, cmd_par} = '0;
    cmd_sel_n = `SEL_NONE;
    reset = 1;
    void'($urandom(32'hA849));
    repeat (8) @(posedge sys_clk);
    #1 reset = 0;
    chk("write_seen", write_seen, 72'h0);
    b = addr_t'($urandom) | addr_t'(3);
    issue(WR, b, 8'h00);
    repeat (3) issue(BU, b, 8'h00);
    issue(RD, b, 8'hFF);
    repeat (3) issue(BU, b, 8'hFF);
    for (int i = 0; i < `LANES; i++) issue(WR, b ^ addr_t'(3), ~(8'h01 << i));
    issue(WR, b, 8'hFF);
    issue(RD, b ^ addr_t'(3), 8'hFF);
    issue(RD, b, 8'hFF);
    repeat (24) issue($urandom_range(1) ? WR : RD, {b[`ADDR_BITS+1:2], 2'($urandom)}, 8'($urandom));
    chk("write_seen", write_seen, 72'h1);
    issue(ID, b, 8'hFF);
    cmd_valid = 0;
    repeat (3) @(posedge sys_clk);
    #1;
    issue(RD, b, 8'hFF);
    issue(RD, b, 8'hFF);
    cmd_valid = 0;
    for (int n = 0; n < 40 && exp_q.size() > 0; n++) @(posedge sys_clk);
    chk("pending_reads", 72'(exp_q.size()), 72'h0);
    end_of_test();
  end
endmodule // testbench
